// ===== core/masp_consts.vh
// Constants for the multichannel audio serial port
`ifndef MASP_CONSTS_VH
`define MASP_CONSTS_VH
`define MASP_ADDR_CTRL   4'h0
`define MASP_ADDR_STAT   4'h1
`define MASP_CTRL_RST    10'h000
`define MASP_C_FMT       2:0
`define MASP_C_WL        4:3
`define MASP_C_BCP       5
`define MASP_C_MS        6
`define MASP_C_IZD       7
`define MASP_C_MUTE      8
`define MASP_C_DEEMPH    9
`define MASP_FMT_LJ      3'h0
`define MASP_FMT_RJ      3'h1
`define MASP_FMT_I2S     3'h2
`define MASP_FMT_DSPA    3'h3
`define MASP_FMT_DSPB    3'h4
`define MASP_WL_16       2'h0
`define MASP_WL_20       2'h1
`define MASP_WL_24       2'h2
`define MASP_WL_32       2'h3
`define MASP_BITS_16     6'h10
`define MASP_BITS_20     6'h14
`define MASP_BITS_24     6'h18
`define MASP_BITS_32     6'h20
`define MASP_DECAY_SH    6
`define MASP_ZERO_RUN    11'h400
`define MASP_MUTE_RUN    11'h400
`define MASP_BCLK_HALF_M1 3'h3
`define MASP_FRM_LAST    9'h03f
`define MASP_FRM_HALF    9'h020
`define MASP_DSP_LAST    9'h0bf
`define MASP_DSP_WLAST   3'h5
`define MASP_TC_MAX      9'h1ff
`endif

// ===== core/masp_top.v
// Multichannel audio serial port: framing, master clocks, mute and automute
// How it works
// (R1) Mode pin high: hardware mode, slave only
// (R2) Silence pin: low normal, high mute, float detect
// (R3) Mute decays to midrail, tau 64 samples
// (R4) Muted 1024 samples with detect: hard midrail
// (R5) 1024 zero samples set the silence latch
// (R6) Pin low needs enable; nonzero clears latch
// (R7) Hardware pins pick format and word length
// (R8) 24-bit I2S accepts shorter words
// (R9) Hardware data pin switches de-emphasis
// (R10) Master bit picks role, slave default
// (R11) Sample rising, launch falling bit clock
// (R12) Invert bit swaps sampling and launch edges
// (R13) Controller changes playback data on falling edge
// (R14) MSB first, 16/20/24/32-bit words
// (R15) Frame halves each at least one word
// (R16) DSP: six words on first input
// (R17) Record-only DSP frame at least two words
// (R18) Left-justified: MSB first edge after transition
// (R19) Right-justified: LSB last edge before transition
// (R20) I2S: MSB second edge, low is left
// (R21) DSP A: MSB second edge after rise
// (R22) DSP B: MSB first edge, fixed word order
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "masp_consts.vh"
module masp_top (
  input  wire         MCLK,
  input  wire         RST_N,
  input  wire [3:0]   ADDR,
  input  wire [15:0]  WDATA,
  input  wire         WR,
  input  wire         RD,
  output wire [15:0]  RDATA,
  input  wire         MODE_PIN,
  input  wire         SILENCE_I,
  input  wire         SILENCE_UNDRIVEN,
  output wire         SILENCE_O,
  output wire         SILENCE_OE,
  input  wire         LATCH_FORMAT_PIN,
  input  wire         CLOCK_WORDLEN_PIN,
  input  wire         DATA_DEEMPHASIS_PIN,
  output wire         DEEMPH_EN,
  input  wire         BCLK_I,
  output wire         BCLK_O,
  output wire         BCLK_OE,
  input  wire         FRAME_I,
  output wire         FRAME_O,
  output wire         FRAME_OE,
  input  wire [2:0]   PLAY_IN,
  output wire         RECORD_OUT,
  input  wire [31:0]  RECORD_L,
  input  wire [31:0]  RECORD_R,
  output wire         RECORD_TAKE,
  output wire [191:0] PLAY_OUT,
  output wire         PLAY_STB,
  output wire         MIDRAIL_CONNECT
);

  function [5:0] wl_bits;
    input [1:0] code;
    begin
      case (code)
        `MASP_WL_16: wl_bits = `MASP_BITS_16;
        `MASP_WL_20: wl_bits = `MASP_BITS_20;
        `MASP_WL_24: wl_bits = `MASP_BITS_24;
        default:     wl_bits = `MASP_BITS_32;
      endcase
    end
  endfunction

  // Two-stage synchronisers for every pin input
  wire [10:0] raw = {PLAY_IN, FRAME_I, BCLK_I, DATA_DEEMPHASIS_PIN, CLOCK_WORDLEN_PIN,
                     LATCH_FORMAT_PIN, SILENCE_UNDRIVEN, SILENCE_I, MODE_PIN};
  reg  [10:0] s1_r;
  reg  [10:0] s2_r;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      s1_r <= 11'h000;
      s2_r <= 11'h000;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  wire       hw_mode   = s2_r[0];
  wire       sil_hi    = s2_r[1];
  wire       sil_float = s2_r[2];
  wire       pin_fmt   = s2_r[3];
  wire       pin_wl    = s2_r[4];
  wire       pin_dm    = s2_r[5];
  wire       bclk_s    = s2_r[6];
  wire       frame_s   = s2_r[7];
  wire [2:0] din       = s2_r[10:8];

  // Control register and register port
  reg  [9:0]  ctrl_r;
  reg  [15:0] rdata_r;
  reg         latch_r;
  reg         midrail_r;
  wire        mute_w;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_r <= `MASP_CTRL_RST; // [R10]
    end else if (WR && ADDR == `MASP_ADDR_CTRL) begin
      ctrl_r <= WDATA[9:0];
    end
  end
  always @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_r <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `MASP_ADDR_CTRL: rdata_r <= {6'h00, ctrl_r};
        `MASP_ADDR_STAT: rdata_r <= {11'h000, sil_float, hw_mode, midrail_r, mute_w, latch_r};
        default:         rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign RDATA = rdata_r;

  // Effective configuration; hardware mode overrides software bits
  reg [2:0] fmt;
  reg [1:0] wlc;
  always @* begin
    if (hw_mode) begin
      fmt = pin_fmt ? `MASP_FMT_I2S : `MASP_FMT_RJ; // [R7]
      case ({pin_fmt, pin_wl})
        2'h0:    wlc = `MASP_WL_24;
        2'h1:    wlc = `MASP_WL_20;
        2'h2:    wlc = `MASP_WL_16;
        default: wlc = `MASP_WL_24; // [R8]
      endcase
    end else begin
      fmt = ctrl_r[`MASP_C_FMT];
      wlc = ctrl_r[`MASP_C_WL];
    end
  end
  wire [5:0] wl     = wl_bits(wlc); // [R14]
  wire       master = ~hw_mode & ctrl_r[`MASP_C_MS]; // [R1] [R10]
  wire       bitclock_invert_bit    = ~hw_mode & ctrl_r[`MASP_C_BCP]; // [R12]
  wire       rj     = (fmt == `MASP_FMT_RJ);
  wire       i2s    = (fmt == `MASP_FMT_I2S);
  wire       dsp    = (fmt == `MASP_FMT_DSPA) | (fmt == `MASP_FMT_DSPB); // [R16]
  wire       off    = i2s | (fmt == `MASP_FMT_DSPA); // [R20] [R21]
  assign DEEMPH_EN = hw_mode ? pin_dm : ctrl_r[`MASP_C_DEEMPH]; // [R9]

  // Master clock generation
  reg [2:0] div_r;
  reg       bgen_r;
  reg       fgen_r;
  reg [8:0] fcnt_r;
  wire      fs_last  = dsp ? (fcnt_r == `MASP_DSP_LAST) : (fcnt_r == `MASP_FRM_LAST);
  wire [8:0] fcnt_nx = fs_last ? 9'h000 : fcnt_r + 9'h001;
  always @(posedge MCLK) begin
    if (!RST_N || !master) begin
      div_r  <= 3'h0;
      bgen_r <= 1'b0;
      fgen_r <= 1'b0;
      fcnt_r <= 9'h000;
    end else if (div_r == `MASP_BCLK_HALF_M1) begin
      div_r  <= 3'h0;
      bgen_r <= ~bgen_r;
      if (~bgen_r == bitclock_invert_bit) begin // Frame moves with the launch edge [R18]
        fcnt_r <= fcnt_nx;
        fgen_r <= dsp ? (fcnt_nx == 9'h000) : (fcnt_nx < `MASP_FRM_HALF);
      end
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign BCLK_O   = bgen_r;
  assign BCLK_OE  = master; // [R10]
  assign FRAME_O  = fgen_r;
  assign FRAME_OE = master;

  // Edge detection of the bit clock
  wire bclk_lvl  = master ? bgen_r : bclk_s;
  wire frame_lvl = master ? fgen_r : frame_s;
  reg  bprev_r;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      bprev_r <= 1'b0;
    end else begin
      bprev_r <= bclk_lvl;
    end
  end
  wire rise   = bclk_lvl & ~bprev_r;
  wire fall   = ~bclk_lvl & bprev_r;
  wire samp   = bitclock_invert_bit ? fall : rise; // [R11] [R12]
  wire launch = bitclock_invert_bit ? rise : fall; // [R11] [R12]

  // Receive path
  reg  [31:0] sh_r [0:2];
  reg  [31:0] pw_r [0:5];
  reg         fs_prev_r;
  reg         arm_r;
  reg         act_r;
  reg         left_r;
  reg  [5:0]  n_r;
  reg  [2:0]  w_r;
  reg         stb_r;
  wire        rev  = dsp ? (frame_lvl & ~fs_prev_r) : (frame_lvl ^ fs_prev_r);
  wire        done = act_r & (n_r == wl) & ~rj;
  wire [5:0]  lsh  = `MASP_BITS_32 - wl;
  integer i;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      fs_prev_r <= 1'b0;
      arm_r     <= 1'b0;
      act_r     <= 1'b0;
      left_r    <= 1'b0;
      n_r       <= 6'h00;
      w_r       <= 3'h0;
      stb_r     <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        sh_r[i] <= 32'h00000000;
      end
      for (i = 0; i < 6; i = i + 1) begin
        pw_r[i] <= 32'h00000000;
      end
    end else begin
      stb_r <= 1'b0;
      if (samp) begin
        fs_prev_r <= frame_lvl;
        for (i = 0; i < 3; i = i + 1) begin
          sh_r[i] <= {sh_r[i][30:0], din[i]}; // [R14]
        end
        if (rj) begin
          if (rev) begin // Word ended on the edge before the transition [R19]
            for (i = 0; i < 3; i = i + 1) begin
              pw_r[2 * i + (fs_prev_r ? 0 : 1)] <= sh_r[i] << lsh;
            end
            stb_r <= ~fs_prev_r;
          end
        end else begin
          if (done) begin
            if (dsp) begin
              pw_r[w_r] <= sh_r[0] << lsh; // [R22]
              stb_r     <= (w_r == `MASP_DSP_WLAST);
            end else begin
              for (i = 0; i < 3; i = i + 1) begin
                pw_r[2 * i + (left_r ? 0 : 1)] <= sh_r[i] << lsh;
              end
              stb_r <= ~left_r;
            end
          end
          if (rev) begin
            w_r    <= 3'h0;
            left_r <= i2s ? ~frame_lvl : frame_lvl; // [R18] [R20]
            arm_r  <= off; // [R20] [R21]
            act_r  <= ~off; // [R18] [R22]
            n_r    <= off ? 6'h00 : 6'h01;
          end else if (arm_r) begin
            arm_r <= 1'b0;
            act_r <= 1'b1;
            n_r   <= 6'h01;
          end else if (done) begin
            if (dsp && w_r != `MASP_DSP_WLAST) begin // Words contiguous [R16] [R22]
              w_r <= w_r + 3'h1;
              n_r <= 6'h01;
            end else begin
              act_r <= 1'b0;
            end
          end else if (act_r) begin
            n_r <= n_r + 6'h01;
          end
        end
      end
    end
  end

  // Transmit path
  reg  [8:0]  tc_r;
  reg  [8:0]  half_r;
  reg         fl_prev_r;
  reg  [31:0] ra_r;
  reg  [31:0] rb_r;
  reg         out_r;
  reg         take_r;
  wire        tev    = dsp ? (frame_lvl & ~fl_prev_r) : (frame_lvl ^ fl_prev_r);
  wire        tleft  = i2s ? ~frame_lvl : frame_lvl;
  wire [8:0]  tc_inc = (tc_r == `MASP_TC_MAX) ? tc_r : tc_r + 9'h001;
  wire [8:0]  tc_use = tev ? 9'h000 : tc_inc;
  wire [8:0]  hf_use = tev ? tc_inc : half_r;
  wire [31:0] wa     = tev ? (dsp ? RECORD_L : (tleft ? RECORD_L : RECORD_R)) : ra_r;
  wire [31:0] wb     = tev ? RECORD_R : rb_r;
  wire [9:0]  start  = rj ? ({1'b0, hf_use} - {4'h0, wl}) : {9'h000, off}; // [R19] [R20]
  wire [9:0]  kk     = {1'b0, tc_use} - start;
  wire [9:0]  span   = dsp ? {3'h0, wl, 1'b0} : {4'h0, wl}; // [R17]
  wire        tvalid = ~kk[9] & (kk < span);
  wire        tsec   = (kk >= {4'h0, wl});
  wire [9:0]  kb     = tsec ? kk - {4'h0, wl} : kk;
  wire [4:0]  bidx   = 5'h1f - kb[4:0];
  wire        tbit   = tsec ? wb[bidx] : wa[bidx]; // [R14]
  always @(posedge MCLK) begin
    if (!RST_N) begin
      tc_r      <= 9'h000;
      half_r    <= 9'h000;
      fl_prev_r <= 1'b0;
      ra_r      <= 32'h00000000;
      rb_r      <= 32'h00000000;
      out_r     <= 1'b0;
      take_r    <= 1'b0;
    end else begin
      take_r <= 1'b0;
      if (launch) begin
        fl_prev_r <= frame_lvl;
        tc_r      <= tc_use;
        out_r     <= tvalid & tbit; // [R11] [R18] [R21] [R22]
        if (tev) begin
          half_r <= tc_inc; // [R15]
          ra_r   <= wa;
          rb_r   <= wb;
          take_r <= 1'b1;
        end
      end
    end
  end
  assign RECORD_OUT  = out_r;
  assign RECORD_TAKE = take_r;

  // Zero detection and mute control
  reg  [10:0] zcnt_r;
  reg  [10:0] mcnt_r;
  reg         ostb_r;
  wire        allz = ~|{pw_r[0], pw_r[1], pw_r[2], pw_r[3], pw_r[4], pw_r[5]};
  wire        izd_eff = ctrl_r[`MASP_C_IZD] | sil_float; // [R2]
  assign mute_w = ctrl_r[`MASP_C_MUTE]
                | (~sil_float & sil_hi) // [R2]
                | (sil_float & latch_r) // [R5]
                | (~sil_float & ~sil_hi & ctrl_r[`MASP_C_IZD] & latch_r); // [R6]
  always @(posedge MCLK) begin
    if (!RST_N) begin
      zcnt_r    <= 11'h000;
      mcnt_r    <= 11'h000;
      latch_r   <= 1'b0;
      midrail_r <= 1'b0;
      ostb_r    <= 1'b0;
    end else begin
      ostb_r <= stb_r;
      if (stb_r) begin
        if (!allz) begin
          zcnt_r  <= 11'h000;
          latch_r <= 1'b0; // [R6]
        end else if (zcnt_r != `MASP_ZERO_RUN) begin
          zcnt_r <= zcnt_r + 11'h001;
          if (zcnt_r + 11'h001 == `MASP_ZERO_RUN) begin
            latch_r <= 1'b1; // [R5]
          end
        end
        if (!mute_w) begin
          mcnt_r    <= 11'h000;
          midrail_r <= 1'b0;
        end else begin
          if (mcnt_r != `MASP_MUTE_RUN) begin
            mcnt_r <= mcnt_r + 11'h001;
          end
          midrail_r <= izd_eff & (mcnt_r + 11'h001 >= `MASP_MUTE_RUN); // [R4]
        end
      end
    end
  end
  assign SILENCE_OE      = sil_float; // [R2]
  assign SILENCE_O       = ~latch_r; // [R2]
  assign MIDRAIL_CONNECT = midrail_r;
  assign PLAY_STB        = ostb_r;

  // Per-channel soft mute with exponential decay
  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : g_ch
      reg [31:0] lvl_r;
      always @(posedge MCLK) begin
        if (!RST_N) begin
          lvl_r <= 32'h00000000;
        end else if (stb_r) begin
          if (!mute_w) begin
            lvl_r <= pw_r[c]; // [R3]
          end else if (midrail_r) begin
            lvl_r <= 32'h00000000; // [R4]
          end else begin
            lvl_r <= lvl_r - {{`MASP_DECAY_SH{lvl_r[31]}}, lvl_r[31:`MASP_DECAY_SH]}; // [R3]
          end
        end
      end
      assign PLAY_OUT[32 * c + 31 : 32 * c] = lvl_r;
    end
  endgenerate

endmodule // masp_top

// ===== verification/masp_checker.sv
// Concurrent checks on the audio serial port top-level ports
`timescale 1ns/100ps
module masp_checker (
  input wire         MCLK,
  input wire         RST_N,
  input wire         MODE_PIN,
  input wire         DATA_DEEMPHASIS_PIN,
  input wire         DEEMPH_EN,
  input wire         SILENCE_UNDRIVEN,
  input wire         SILENCE_OE,
  input wire         BCLK_O,
  input wire         BCLK_OE,
  input wire         FRAME_OE,
  input wire         PLAY_STB,
  input wire         FRAME_O,
  input wire         RECORD_TAKE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  AST_HW_SLAVE: assert property (MODE_PIN [*5] |-> !BCLK_OE && !FRAME_OE)
    else $error("clock drive in hardware mode");
  AST_ROLE_PAIR: assert property (BCLK_OE == FRAME_OE)
    else $error("clock enables differ");
  AST_BCLK_RATE: assert property (disable iff (!RST_N || !BCLK_OE)
    $rose(BCLK_O) |-> BCLK_O [*4] ##1 !BCLK_O [*4])
    else $error("bit clock period wrong");
  AST_SIL_OE_ON: assert property (SILENCE_UNDRIVEN [*5] |-> SILENCE_OE)
    else $error("silence pin not driven");
  AST_SIL_OE_OFF: assert property (!SILENCE_UNDRIVEN [*5] |-> !SILENCE_OE)
    else $error("silence pin driven");
  AST_STB_GAP: assert property (PLAY_STB |=> !PLAY_STB [*8])
    else $error("strobes too close");
  AST_DM_ON: assert property ((MODE_PIN && DATA_DEEMPHASIS_PIN) [*5] |-> DEEMPH_EN)
    else $error("de-emphasis off");
  AST_DM_OFF: assert property ((MODE_PIN && !DATA_DEEMPHASIS_PIN) [*5] |-> !DEEMPH_EN)
    else $error("de-emphasis on");
  AST_FRAME_ON_EDGE: assert property (disable iff (!RST_N || !FRAME_OE)
    $changed(FRAME_O) |-> $changed(BCLK_O))
    else $error("frame clock moved off a bit clock edge");
  AST_TAKE_GAP: assert property (RECORD_TAKE |=> !RECORD_TAKE [*8])
    else $error("record words taken too often");
endmodule // masp_checker

// ===== verification/masp_partner.sv
// Controller model driving bit clock, frame clock and playback data
`timescale 1ns/100ps
`include "masp_consts.vh"
module masp_partner (
  input  wire        run,
  input  wire [2:0]  fmt,
  input  wire [95:0] words,
  input  wire        rec,
  output logic       bclk,
  output logic       frame,
  output logic [2:0] din,
  output logic       frm_start,
  output logic [31:0] rec_got
);
  logic [95:0] w;
  logic [31:0] rg;
  integer      h, c, j, k, off;
  initial begin
    bclk = 1'b0;
    frame = 1'b0;
    din = 3'h5;
    frm_start = 1'b0;
    rg = 32'h0;
    rec_got = 32'h0;
    #7;
    forever begin
      if (!run) begin
        #40;
        frame = (fmt == `MASP_FMT_I2S);
        din = ~din;
      end else begin
        if (!bclk) begin // Lead-in clock so each frame starts on a falling edge
          bclk = 1'b1;
          #160;
        end
        w = words;
        frm_start = 1'b1;
        off = (fmt == `MASP_FMT_RJ) ? 16 : (fmt == `MASP_FMT_I2S) ? 1 : 0;
        for (h = 0; h < 2; h++) begin
          for (c = 0; c < 32; c++) begin
            bclk = 1'b0;
            frame = (h == 0) ^ (fmt == `MASP_FMT_I2S);
            j = c - off;
            for (k = 0; k < 3; k++)
              din[k] = (j >= 0 && j < 16) ? w[(2 * k + h) * 16 + 15 - j] : ~din[k];
            #160;
            if (j >= 0 && j < 16)
              rg[(1 - h) * 16 + 15 - j] = rec;
            bclk = 1'b1;
            frm_start = 1'b0;
            #160;
          end
        end
        rec_got = rg;
      end
    end
  end
endmodule // masp_partner

// ===== verification/tb_multichannel_audio_serial_port.sv
// Self-checking bench for the audio serial port
`timescale 1ns/100ps
`include "masp_consts.vh"
module tb_multichannel_audio_serial_port;
  logic         mclk, rst_n, wr, rd, mode_pin, sil_i, sil_und, fmt_l, fmt_c, dm_pin, run;
  logic [3:0]   addr;
  logic [15:0]  wdata, v;
  logic [31:0]  rec_l, rec_r;
  logic [95:0]  words;
  logic [2:0]   pfmt;
  logic [191:0] exp;
  logic [95:0]  q[$];
  wire  [15:0]  rdata;
  wire  [191:0] play_out;
  wire          play_stb, bclk_oe, deemph_en, sil_o, sil_oe, bclk, frame, frm_start;
  wire  [2:0]   din;
  wire          rec_out;
  wire  [31:0]  rec_got;
  integer       seed = 24;
  integer       n_mismatch = 0;
  integer       num_checks = 0;

  masp_top uut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MODE_PIN(mode_pin), .SILENCE_I(sil_i), .SILENCE_UNDRIVEN(sil_und),
    .SILENCE_O(sil_o), .SILENCE_OE(sil_oe), .LATCH_FORMAT_PIN(fmt_l),
    .CLOCK_WORDLEN_PIN(fmt_c), .DATA_DEEMPHASIS_PIN(dm_pin), .DEEMPH_EN(deemph_en),
    .BCLK_I(bclk), .BCLK_O(), .BCLK_OE(bclk_oe), .FRAME_I(frame), .FRAME_O(), .FRAME_OE(),
    .PLAY_IN(din), .RECORD_OUT(rec_out), .RECORD_L(rec_l), .RECORD_R(rec_r), .RECORD_TAKE(),
    .PLAY_OUT(play_out), .PLAY_STB(play_stb), .MIDRAIL_CONNECT());
  masp_partner prt (.run(run), .fmt(pfmt), .words(words), .bclk(bclk), .frame(frame),
    .din(din), .frm_start(frm_start), .rec(rec_out), .rec_got(rec_got));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge frm_start) begin
    q.push_back(words);
    words <= {$random(seed), $random(seed), $random(seed)};
  end

  task automatic chk(input string nm, input logic [191:0] e, input logic [191:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
    @(posedge mclk);
  endtask

  task automatic play(input logic [2:0] f, input integer n);
    integer i, k;
    logic [95:0] w;
    pfmt <= f;
    repeat (100) @(posedge mclk);
    q.delete();
    run <= 1'b1;
    // Right-justified: the first strobe closes a word sent before the link started
    for (k = (f == `MASP_FMT_RJ) ? -1 : 0; k < n; k++) begin
      i = 0;
      do begin
        @(posedge mclk);
        #1 i++;
      end while (i < 2000 && play_stb !== 1'b1);
      if (play_stb !== 1'b1) begin
        n_mismatch++;
        $display("Error play strobe expected pulse seen none");
      end
      if (k >= 0) begin
        w = q.pop_front();
        for (i = 0; i < 6; i++)
          exp[32 * i +: 32] = {w[16 * i +: 16], 16'h0};
        chk("play words", exp, play_out);
        if (k > 0 || f == `MASP_FMT_RJ)
          chk("record word", {rec_l[31:16], rec_r[31:16]}, rec_got);
      end
    end
    run <= 1'b0;
    repeat (1500) @(posedge mclk);
    $display("test format %0d done", f);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    {rst_n, wr, rd, mode_pin, sil_i, sil_und, fmt_l, fmt_c, dm_pin, run} = 10'h000;
    addr = 4'h0;
    wdata = 16'h0;
    pfmt = 3'h0;
    rec_l = $random(seed);
    rec_r = $random(seed);
    words = {$random(seed), $random(seed), $random(seed)};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(`MASP_ADDR_CTRL);
    chk("ctrl reset", `MASP_CTRL_RST, v);
    rd_reg(4'hf);
    chk("unmapped", 16'h0, v);
    chk("slave default", 1'b0, bclk_oe);
    $display("test registers done");
    sil_i <= 1'b1;
    repeat (6) @(posedge mclk);
    rd_reg(`MASP_ADDR_STAT);
    chk("pin mute", 1'b1, v[1]);
    sil_i <= 1'b0;
    wr_reg(`MASP_ADDR_CTRL, 16'h0001 << `MASP_C_MUTE);
    rd_reg(`MASP_ADDR_STAT);
    chk("soft mute", 1'b1, v[1]);
    wr_reg(`MASP_ADDR_CTRL, 16'h0000);
    sil_und <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("float drive", 2'h3, {sil_oe, sil_o});
    sil_und <= 1'b0;
    $display("test silence done");
    play(`MASP_FMT_LJ, 4);
    wr_reg(`MASP_ADDR_CTRL, {13'h0, `MASP_FMT_RJ});
    play(`MASP_FMT_RJ, 4);
    wr_reg(`MASP_ADDR_CTRL, 16'h0001 << `MASP_C_MS);
    repeat (10) @(posedge mclk);
    chk("master role", 1'b1, bclk_oe);
    repeat (100) @(posedge mclk);
    mode_pin <= 1'b1;
    fmt_l <= 1'b1;
    dm_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("hw slave", 2'h1, {bclk_oe, deemph_en});
    play(`MASP_FMT_I2S, 4);
    dm_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("hw deemph off", 1'b0, deemph_en);
    print_verdict;
  end

  initial begin
    #2000000;
    n_mismatch++;
    $display("Error watchdog expected done seen timeout");
    print_verdict;
  end
endmodule // tb_multichannel_audio_serial_port

bind masp_top masp_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .MODE_PIN(MODE_PIN),
  .DATA_DEEMPHASIS_PIN(DATA_DEEMPHASIS_PIN), .DEEMPH_EN(DEEMPH_EN),
  .SILENCE_UNDRIVEN(SILENCE_UNDRIVEN), .SILENCE_OE(SILENCE_OE), .BCLK_O(BCLK_O),
  .BCLK_OE(BCLK_OE), .FRAME_OE(FRAME_OE), .PLAY_STB(PLAY_STB), .FRAME_O(FRAME_O),
  .RECORD_TAKE(RECORD_TAKE));
